// file: bench/cpu8_instruction_decode_tail_assertions.sv
`timescale 1ns/100ps
`include "cpu8_consts.svh"
module cpu8_instruction_decode_tail_assertions (
    input wire logic                clk,
    input wire logic                rst_n,
    input wire logic [7:0]          bus_rdata,
    input wire logic                irq_req_n,
    input wire logic                debug_resume,
    input wire cpu8_pkg::bus_req_s  bus,
    input wire cpu8_pkg::cpu_regs_s regs,
    input wire logic                wait_halted,
    input wire logic                debug_halted
);
    import cpu8_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence vec_hi_s;
        bus.kind == cyc_vector && !bus.addr[0];
    endsequence
    sequence vec_lo_s;
        bus.kind == cyc_vector && bus.addr == $past(bus.addr) + `ONE16;
    endsequence
    sequence push_s;
        bus.kind == cyc_push && bus.addr == regs.sp;
    endsequence
    sequence pop_s;
        bus.kind == cyc_pop && bus.addr == regs.sp + `ONE16;
    endsequence

    chk_free_read: assert property (
        bus.kind == cyc_free |-> bus.rd && !bus.wr) else $error("free cycle not a read");
    chk_write_strobe: assert property (
        bus.kind inside {cyc_write, cyc_push} |-> bus.wr && !bus.rd)
        else $error("write cycle strobes wrong");
    chk_read_strobe: assert property (
        bus.kind inside {cyc_prog, cyc_read, cyc_pop, cyc_vector} |-> bus.rd && !bus.wr)
        else $error("read cycle strobes wrong");
    chk_vector_page: assert property (
        bus.kind == cyc_vector |-> bus.addr[15:8] == `VEC_PAGE) else $error("vector off page");
    chk_vector_pair: assert property (
        vec_hi_s |=> vec_lo_s) else $error("vector low byte not next");
    chk_push_order: assert property (
        bus.kind == cyc_push |-> push_s ##1 regs.sp == $past(regs.sp) - `ONE16)
        else $error("push address or pointer wrong");
    chk_pop_order: assert property (
        bus.kind == cyc_pop |-> pop_s ##1 regs.sp == $past(regs.sp) + `ONE16)
        else $error("pop address or pointer wrong");
    chk_wait_idle: assert property (
        wait_halted |-> bus.kind == cyc_free && !regs.flags[`FLAG_I])
        else $error("halted core not idle or masked");
    chk_wait_wake: assert property (
        wait_halted && !irq_req_n |-> ##[1:6] bus.kind == cyc_push)
        else $error("halted core ignored interrupt");
    chk_debug_idle: assert property (
        debug_halted |-> bus.kind == cyc_free) else $error("debug halt uses bus");
    chk_debug_exit: assert property (
        debug_halted && debug_resume |-> ##[1:6] !debug_halted)
        else $error("debug halt not left");
endmodule : cpu8_instruction_decode_tail_assertions

// file: bench/cpu8_instruction_decode_tail_tb_top.sv
`timescale 1ns/100ps
`include "cpu8_consts.svh"
module cpu8_instruction_decode_tail_tb_top;
    import cpu8_pkg::*;
    localparam int NROWS = 62;
    logic        clk;
    logic        rst_n;
    logic        irq_req_n;
    logic        debug_resume;
    logic [7:0]  bus_rdata;
    bus_req_s    bus;
    cpu_regs_s   regs;
    logic        wait_halted;
    logic        debug_halted;
    int          failures;
    int          cmp_count;
    int          i;
    int          n;
    // expected cycles from reset: kind nibble, then address (not checked on free cycles)
    logic [19:0] rows [NROWS] = '{
        20'h6fffe, 20'h6ffff, 20'h00000, 20'h10100, 20'h10100, 20'h10100,
        20'h00000, 20'h10101, 20'h10102, 20'h20040, 20'h10103, 20'h10104, 20'h30041,
        20'h10105, 20'h10106, 20'h201ff, 20'h10107, 20'h10108, 20'h10109, 20'h20101,
        20'h1010a, 20'h20100, 20'h1010b, 20'h00000, 20'h1010c, 20'h00000,
        20'h1010d, 20'h1010e, 20'h20042, 20'h00000, 20'h30042,
        20'h1010f, 20'h10110, 20'h20043, 20'h00000, 20'h30043,
        20'h10111, 20'h40100, 20'h400ff, 20'h400fe, 20'h400fd, 20'h400fc,
        20'h6fffc, 20'h6fffd, 20'h00000, 20'h10200, 20'h10200, 20'h10200,
        20'h500fc, 20'h500fd, 20'h500fe, 20'h500ff, 20'h50100,
        20'h00000, 20'h10112, 20'h10112, 20'h10112, 20'h10113, 20'h00000,
        20'h10116, 20'h00000, 20'h10117};
    logic [7:0]  code [23] = '{8'h95, 8'hb6, 8'h40, 8'hb7, 8'h41, 8'he6, 8'hff, 8'h9e,
        8'he6, 8'h02, 8'h71, 8'h10, 8'h94, 8'h14, 8'h42, 8'h15, 8'h43, 8'h83, 8'h20,
        8'h02, 8'h00, 8'h00, 8'h8f};

    cpu8_instruction_decode_tail dut (
        .clk(clk), .rst_n(rst_n), .bus_rdata(bus_rdata), .irq_req_n(irq_req_n),
        .debug_resume(debug_resume), .bus(bus), .regs(regs), .wait_halted(wait_halted),
        .debug_halted(debug_halted));
    cpu8_mem_model memory (.clk(clk), .bus(bus), .rdata(bus_rdata));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask : check

    task automatic results;
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    task automatic give_up(input string what);
        $display("BAD %s expected reached seen timeout", what);
        failures++;
        results();
    endtask : give_up

    task automatic wait_kind(input bus_cycle_e k, input logic [15:0] a, input int lim);
        int c;
        for (c = 0; c < lim && !(bus.kind === k && bus.addr === a); c++) @(negedge clk);
        cmp_count++;
        if (!(bus.kind === k && bus.addr === a)) give_up("bus cycle");
    endtask : wait_kind

    task automatic do_reset(input int cycles);
        rst_n = 1'b0;
        repeat (cycles) @(negedge clk);
        check("reset state", {`ZERO8, `ZERO16, `SP_RESET, `ZERO16, `FLAGS_RESET}, regs);
        rst_n = 1'b1;
    endtask : do_reset

    initial begin
        rst_n = 1'b0;
        irq_req_n = 1'b1;
        debug_resume = 1'b0;
        failures = 0;
        cmp_count = 0;
        for (i = 0; i < 65536; i++) memory.mem[i] = 8'h00;
        for (i = 0; i < 23; i++) memory.mem[16'h0100 + i] = code[i];
        memory.mem[16'hfffe] = 8'h01;
        memory.mem[16'hfffc] = 8'h02;
        memory.mem[16'hfffa] = 8'h03;
        memory.mem[16'h0040] = 8'h5a;
        memory.mem[16'h0043] = 8'hff;
        memory.mem[16'h0200] = 8'h80;
        memory.mem[16'h0300] = 8'h82;
        memory.mem[16'h0301] = 8'h20;
        memory.mem[16'h0302] = 8'h80;
        memory.mem[16'h0283] = 8'h20;
        memory.mem[16'h0284] = 8'hfe;
        do_reset(12);
        wait_kind(cyc_vector, 16'hfffe, 4);
        for (i = 0; i < NROWS; i++) begin
            check("cycle kind", rows[i][19:16], bus.kind);
            if (rows[i][19:16] != 4'h0) begin
                check("cycle address", rows[i][15:0], bus.addr);
            end
            @(negedge clk);
        end
        for (n = 0; n < 8 && wait_halted !== 1'b1; n++) @(negedge clk);
        check("halted", 1'b1, wait_halted);
        check("mask bit", 1'b0, regs.flags[`FLAG_I]);
        check("index pair", 16'h0101, regs.hx);
        check("stack pointer", 16'h0100, regs.sp);
        check("accumulator", 8'hb6, regs.a);
        check("direct store", 8'h5a, memory.mem[16'h0041]);
        check("bit set", 8'h04, memory.mem[16'h0042]);
        check("bit clear", 8'hfb, memory.mem[16'h0043]);
        check("stacked low pc", 8'h12, memory.mem[16'h0100]);
        check("stacked high pc", 8'h01, memory.mem[16'h00ff]);
        irq_req_n = 1'b0;
        wait_kind(cyc_vector, 16'hfffa, 20);
        irq_req_n = 1'b1;
        for (n = 0; n < 30 && debug_halted !== 1'b1; n++) @(negedge clk);
        check("debug halt", 1'b1, debug_halted);
        debug_resume = 1'b1;
        for (n = 0; n < 8 && debug_halted !== 1'b0; n++) @(negedge clk);
        check("debug resume", 1'b0, debug_halted);
        debug_resume = 1'b0;
        wait_kind(cyc_prog, 16'h0283, 20);
        do_reset(2);
        wait_kind(cyc_vector, 16'hfffe, 4);
        results();
    end
endmodule : cpu8_instruction_decode_tail_tb_top

bind cpu8_instruction_decode_tail cpu8_instruction_decode_tail_assertions chk_i (
    .clk(clk), .rst_n(rst_n), .bus_rdata(bus_rdata), .irq_req_n(irq_req_n),
    .debug_resume(debug_resume), .bus(bus), .regs(regs), .wait_halted(wait_halted),
    .debug_halted(debug_halted));

// file: bench/cpu8_mem_model.sv
`timescale 1ns/100ps
module cpu8_mem_model (
    input  wire logic               clk,
    input  wire cpu8_pkg::bus_req_s bus,
    output logic [7:0]              rdata
);
    import cpu8_pkg::*;
    logic [7:0] mem [0:65535];
    logic [7:0] last_r;

    // zero-wait memory: every edge ends one bus cycle, no stall possible
    always @(posedge clk) begin
        if (bus.wr) begin
            mem[bus.addr] <= bus.wdata;
        end
        last_r <= rdata;
    end

    // data bus not read: show the inverse of the last byte, never a stale copy
    assign rdata = bus.rd ? mem[bus.addr] : ~last_r;
endmodule : cpu8_mem_model

// file: hdl/cpu8_consts.svh
`ifndef CPU8_CONSTS_SVH
`define CPU8_CONSTS_SVH
`define OP_RET_INT    8'h80
`define OP_RTS        8'h81
`define OP_DBG_ENTRY  8'h82
`define OP_SOFT_TRAP  8'h83
`define OP_WAIT       8'h8f
`define OP_IDX_TO_SP  8'h94
`define OP_SP_TO_IDX  8'h95
`define OP_PREFIX     8'h9e
`define OP_BRA        8'h20
`define OP_CBEQ_IX1P  8'h61
`define OP_CBEQ_IXP   8'h71
`define OP_LDA_DIR    8'hb6
`define OP_STA_DIR    8'hb7
`define OP_LDA_IX2    8'hd6
`define OP_LDA_IX1    8'he6
`define OP_LDA_IX     8'hf6
`define OP_BIT_GRP    4'h1
`define VEC_PAGE      8'hff
`define VEC_RESET     8'hfe
`define VEC_TRAP      8'hfc
`define VEC_IRQ       8'hfa
`define INT_VEC_STEP  4'h5
`define SP_RESET      16'h00ff
`define FLAGS_RESET   8'h68
`define FLAGS_FIXED   8'h60
`define FLAG_V        7
`define FLAG_I        3
`define FLAG_N        2
`define FLAG_Z        1
`define ONE16         16'h0001
`define ZERO16        16'h0000
`define ZERO8         8'h00
`endif

// file: hdl/cpu8_instruction_decode_tail.sv
// Operation
// - stack pointer gets index pair minus one
// - index pair gets stack pointer plus one
// - wait clears interrupt mask, then halts
// - free cycle is one read, unused
// - program fetch reads next byte; advances on opcode and operand fetches only
// - operand cycles read or write one byte
// - push writes stack, pop reads stack
// - vector read from page ff, high first
// - branch displacement signed, from next instruction
// - direct mode high address byte zero
// - 8-bit index offset zero-extended
// - post-increment modes bump index after access
// - stack-relative address adds offset to stack
// - bit number field selects one bit
// - control opcodes take their fixed cycles
`timescale 1ns/100ps
`include "cpu8_consts.svh"
module cpu8_instruction_decode_tail (
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic [7:0]     bus_rdata,
    input  wire logic           irq_req_n,
    input  wire logic           debug_resume,
    output cpu8_pkg::bus_req_s  bus,
    output cpu8_pkg::cpu_regs_s regs,
    output logic                wait_halted,
    output logic                debug_halted
);
    import cpu8_pkg::*;

    seq_state_e  state_r, state_nxt;
    cpu_regs_s   r_r, r_nxt;
    logic [7:0]  opcode_r, opcode_nxt;
    logic        prefix_r, prefix_nxt;
    logic [3:0]  step_r, step_nxt;
    logic [15:0] off_r, off_nxt;
    logic [7:0]  data_r, data_nxt;
    logic [7:0]  vec_r, vec_nxt;
    logic        irq_meta_r, irq_sync_r;
    logic        res_meta_r, res_sync_r;
    bus_req_s    bus_c;
    ea_mode_e    ea_mode;
    logic [15:0] ea;
    logic        is_mem;
    logic        is_cbeq;
    logic        is_bit;
    logic [3:0]  nofs;
    logic        irq_pend;
    logic [7:0]  bit_mask;
    logic [7:0]  mem_val;

    ea_calc u_ea (
        .mode (ea_mode),
        .hx   (r_r.hx),
        .sp   (r_r.sp),
        .pc   (r_r.pc),
        .off  (off_r),
        .ea   (ea)
    );

    assign irq_pend     = !irq_sync_r && !r_r.flags[`FLAG_I] && !prefix_r;
    assign bit_mask     = 8'h01 << opcode_r[3:1];
    assign bus          = bus_c;
    assign regs         = r_r;
    assign wait_halted  = (state_r == st_halt);
    assign debug_halted = (state_r == st_debug);

    // pin synchronisers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_meta_r <= 1'b1;
            irq_sync_r <= 1'b1;
            res_meta_r <= 1'b0;
            res_sync_r <= 1'b0;
        end else begin
            irq_meta_r <= irq_req_n;
            irq_sync_r <= irq_meta_r;
            res_meta_r <= debug_resume;
            res_sync_r <= res_meta_r;
        end
    end

    // addressing decode
    always_comb begin
        is_mem  = 1'b0;
        is_cbeq = 1'b0;
        nofs    = 4'h0;
        ea_mode = ea_direct;
        case (opcode_r)
            `OP_LDA_DIR, `OP_STA_DIR: begin
                is_mem = 1'b1;
                nofs   = 4'h1;
            end
            `OP_LDA_IX1: begin
                is_mem  = 1'b1;
                nofs    = 4'h1;
                ea_mode = prefix_r ? ea_stack_off : ea_index_off;
            end
            `OP_LDA_IX2: begin
                is_mem  = 1'b1;
                nofs    = 4'h2;
                ea_mode = prefix_r ? ea_stack_off : ea_index_off;
            end
            `OP_LDA_IX: begin
                is_mem  = 1'b1;
                ea_mode = ea_index_off;
            end
            `OP_CBEQ_IX1P: begin
                is_cbeq = 1'b1;
                nofs    = 4'h1;
                ea_mode = (step_r > 4'h1) ? ea_pc_rel : ea_index_off;
            end
            `OP_CBEQ_IXP: begin
                is_cbeq = 1'b1;
                ea_mode = (step_r > 4'h0) ? ea_pc_rel : ea_index_off;
            end
            `OP_BRA: ea_mode = ea_pc_rel;
            default: ;
        endcase
        is_bit = (opcode_r[7:4] == `OP_BIT_GRP);
    end

    // sequencer
    always_comb begin
        state_nxt  = state_r;
        r_nxt      = r_r;
        opcode_nxt = opcode_r;
        prefix_nxt = prefix_r;
        step_nxt   = step_r + 4'h1;
        off_nxt    = off_r;
        data_nxt   = data_r;
        vec_nxt    = vec_r;
        mem_val    = bus_rdata;
        bus_c      = '{addr: r_r.pc, wdata: `ZERO8, rd: 1'b1, wr: 1'b0, kind: cyc_free};
        unique case (state_r)
            st_fetch: begin
                step_nxt = 4'h0;
                off_nxt  = `ZERO16;
                if (irq_pend) begin
                    state_nxt = st_intr;
                    vec_nxt   = `VEC_IRQ;
                end else begin
                    bus_c.kind = cyc_prog;
                    r_nxt.pc   = r_r.pc + `ONE16;
                    if (bus_rdata == `OP_PREFIX) begin
                        prefix_nxt = 1'b1;
                    end else if (bus_rdata == `OP_SOFT_TRAP) begin
                        state_nxt = st_intr;
                        vec_nxt   = `VEC_TRAP;
                    end else begin
                        opcode_nxt = bus_rdata;
                        state_nxt  = st_exec;
                    end
                end
            end
            st_intr: begin
                if (step_r < `INT_VEC_STEP) begin
                    bus_c.addr = r_r.sp;
                    bus_c.rd   = 1'b0;
                    bus_c.wr   = 1'b1;
                    bus_c.kind = cyc_push;
                    r_nxt.sp   = r_r.sp - `ONE16;
                    case (step_r)
                        4'h0:    bus_c.wdata = r_r.pc[7:0];
                        4'h1:    bus_c.wdata = r_r.pc[15:8];
                        4'h2:    bus_c.wdata = r_r.hx[7:0];
                        4'h3:    bus_c.wdata = r_r.a;
                        default: begin
                            bus_c.wdata          = r_r.flags;
                            r_nxt.flags[`FLAG_I] = 1'b1;
                        end
                    endcase
                end else if (step_r == `INT_VEC_STEP) begin
                    bus_c.addr      = {`VEC_PAGE, vec_r};
                    bus_c.kind      = cyc_vector;
                    r_nxt.pc[15:8]  = bus_rdata;
                end else if (step_r == 4'h6) begin
                    bus_c.addr      = {`VEC_PAGE, vec_r + 8'h01};
                    bus_c.kind      = cyc_vector;
                    r_nxt.pc[7:0]   = bus_rdata;
                end else if (step_r != 4'h7) begin
                    bus_c.kind = cyc_prog;
                    if (step_r == 4'h9) begin
                        state_nxt = st_fetch;
                    end
                end
            end
            st_halt: begin
                step_nxt = 4'h0;
                if (irq_pend) begin
                    state_nxt = st_intr;
                    vec_nxt   = `VEC_IRQ;
                end
            end
            st_debug: begin
                step_nxt = 4'h0;
                if (res_sync_r) begin
                    state_nxt = st_fetch;
                end
            end
            st_exec: begin
                if (is_mem || is_cbeq || is_bit || opcode_r == `OP_BRA) begin
                    if (step_r < nofs || (is_bit && step_r == 4'h0)
                            || (opcode_r == `OP_BRA && step_r == 4'h0)) begin
                        bus_c.kind = cyc_prog;
                        r_nxt.pc   = r_r.pc + `ONE16;
                        off_nxt    = {off_r[7:0], bus_rdata};
                    end else if (opcode_r == `OP_BRA) begin
                        r_nxt.pc  = ea;
                        state_nxt = st_fetch;
                    end else if (is_mem) begin
                        bus_c.addr = ea;
                        state_nxt  = st_fetch;
                        if (opcode_r == `OP_STA_DIR) begin
                            bus_c.rd    = 1'b0;
                            bus_c.wr    = 1'b1;
                            bus_c.wdata = r_r.a;
                            bus_c.kind  = cyc_write;
                            mem_val     = r_r.a;
                        end else begin
                            bus_c.kind = cyc_read;
                            r_nxt.a    = bus_rdata;
                        end
                        r_nxt.flags[`FLAG_N] = mem_val[7];
                        r_nxt.flags[`FLAG_Z] = (mem_val == `ZERO8);
                        r_nxt.flags[`FLAG_V] = 1'b0;
                    end else if (is_bit) begin
                        bus_c.addr = ea;
                        if (step_r == 4'h1) begin
                            bus_c.kind = cyc_read;
                            data_nxt   = bus_rdata;
                        end else if (step_r == 4'h3) begin
                            bus_c.rd    = 1'b0;
                            bus_c.wr    = 1'b1;
                            bus_c.kind  = cyc_write;
                            bus_c.wdata = opcode_r[0] ? (data_r & ~bit_mask)
                                                      : (data_r | bit_mask);
                            state_nxt   = st_fetch;
                        end
                    end else if (step_r == nofs) begin
                        bus_c.addr = ea;
                        bus_c.kind = cyc_read;
                        data_nxt   = bus_rdata;
                        r_nxt.hx   = r_r.hx + `ONE16;
                    end else if (step_r == nofs + 4'h1) begin
                        bus_c.kind = cyc_prog;
                        r_nxt.pc   = r_r.pc + `ONE16;
                        off_nxt    = {`ZERO8, bus_rdata};
                    end else begin
                        if (r_r.a == data_r) begin
                            r_nxt.pc = ea;
                        end
                        state_nxt = st_fetch;
                    end
                end else begin
                    case (opcode_r)
                        `OP_IDX_TO_SP: begin
                            r_nxt.sp  = r_r.hx - `ONE16;
                            state_nxt = st_fetch;
                        end
                        `OP_SP_TO_IDX: begin
                            r_nxt.hx  = r_r.sp + `ONE16;
                            state_nxt = st_fetch;
                        end
                        `OP_WAIT: begin
                            if (step_r == 4'h0) begin
                                r_nxt.flags[`FLAG_I] = 1'b0;
                            end else begin
                                bus_c.kind = cyc_prog;
                                state_nxt  = st_halt;
                            end
                        end
                        `OP_RET_INT, `OP_RTS: begin
                            if ((opcode_r == `OP_RET_INT && step_r < 4'h5)
                                    || (opcode_r == `OP_RTS && step_r < 4'h2)) begin
                                bus_c.addr = r_r.sp + `ONE16;
                                bus_c.kind = cyc_pop;
                                r_nxt.sp   = r_r.sp + `ONE16;
                                case (opcode_r == `OP_RET_INT ? step_r : step_r + 4'h3)
                                    4'h0:    r_nxt.flags    = bus_rdata | `FLAGS_FIXED;
                                    4'h1:    r_nxt.a        = bus_rdata;
                                    4'h2:    r_nxt.hx[7:0]  = bus_rdata;
                                    4'h3:    r_nxt.pc[15:8] = bus_rdata;
                                    default: r_nxt.pc[7:0]  = bus_rdata;
                                endcase
                            end else if ((opcode_r == `OP_RET_INT && step_r != 4'h5)
                                    || (opcode_r == `OP_RTS && step_r != 4'h2)) begin
                                bus_c.kind = cyc_prog;
                                if ((opcode_r == `OP_RET_INT && step_r == 4'h7)
                                        || (opcode_r == `OP_RTS && step_r == 4'h4)) begin
                                    state_nxt = st_fetch;
                                end
                            end
                        end
                        `OP_DBG_ENTRY: begin
                            if (step_r == 4'h2) begin
                                state_nxt = st_debug;
                            end
                        end
                        default: state_nxt = st_fetch;
                    endcase
                end
            end
            default: state_nxt = st_fetch;
        endcase
        if (state_nxt == st_fetch && state_r != st_fetch) begin
            prefix_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r  <= st_intr;
            step_r   <= `INT_VEC_STEP;
            vec_r    <= `VEC_RESET;
            r_r      <= '{a: `ZERO8, hx: `ZERO16, sp: `SP_RESET, pc: `ZERO16,
                          flags: `FLAGS_RESET};
            opcode_r <= `ZERO8;
            prefix_r <= 1'b0;
            off_r    <= `ZERO16;
            data_r   <= `ZERO8;
        end else begin
            state_r  <= state_nxt;
            step_r   <= step_nxt;
            vec_r    <= vec_nxt;
            r_r      <= r_nxt;
            opcode_r <= opcode_nxt;
            prefix_r <= prefix_nxt;
            off_r    <= off_nxt;
            data_r   <= data_nxt;
        end
    end
endmodule : cpu8_instruction_decode_tail

// file: hdl/cpu8_pkg.sv
package cpu8_pkg;
    typedef enum logic [2:0] {
        st_fetch = 3'b000,
        st_exec  = 3'b001,
        st_intr  = 3'b010,
        st_halt  = 3'b011,
        st_debug = 3'b100
    } seq_state_e;

    typedef enum logic [2:0] {
        cyc_free   = 3'b000,
        cyc_prog   = 3'b001,
        cyc_read   = 3'b010,
        cyc_write  = 3'b011,
        cyc_push   = 3'b100,
        cyc_pop    = 3'b101,
        cyc_vector = 3'b110
    } bus_cycle_e;

    typedef enum logic [1:0] {
        ea_direct    = 2'b00,
        ea_index_off = 2'b01,
        ea_stack_off = 2'b10,
        ea_pc_rel    = 2'b11
    } ea_mode_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        rd;
        logic        wr;
        bus_cycle_e  kind;
    } bus_req_s;

    typedef struct packed {
        logic [7:0]  a;
        logic [15:0] hx;
        logic [15:0] sp;
        logic [15:0] pc;
        logic [7:0]  flags;
    } cpu_regs_s;
endpackage : cpu8_pkg

// file: hdl/ea_calc.sv
`timescale 1ns/100ps
`include "cpu8_consts.svh"
module ea_calc (
    input  cpu8_pkg::ea_mode_e mode,
    input  wire logic [15:0]   hx,
    input  wire logic [15:0]   sp,
    input  wire logic [15:0]   pc,
    input  wire logic [15:0]   off,
    output logic [15:0]        ea
);
    import cpu8_pkg::*;

    always_comb begin
        unique case (mode)
            ea_direct:    ea = {`ZERO8, off[7:0]};
            ea_index_off: ea = hx + off;
            ea_stack_off: ea = sp + off;
            ea_pc_rel:    ea = pc + {{8{off[7]}}, off[7:0]};
        endcase
    end
endmodule : ea_calc
